// ---- mdcx_pkg.sv ----
// Shared types and constants for the motion drive command executor.
// Assumes one 10 MHz clock domain; counts are in clock cycles.
package mdcx_pkg;

   // Program line command codes.
   typedef enum logic [3:0] {
      CMD_NOP                      = 4'h0,
      CMD_RELATIVE_MOVE            = 4'h1,
      CMD_DUAL_AXIS_RELATIVE_MOVE  = 4'h2,
      CMD_RELATIVE_MOVE_START      = 4'h3,
      CMD_CONTINUOUS_MOVE_START    = 4'h4,
      CMD_DECELERATING_STOP        = 4'h5,
      CMD_IMMEDIATE_STOP           = 4'h6,
      CMD_ORIGIN_SEARCH            = 4'h7
   } mdcx_cmd_t;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_ISSUE  = 3'h1,
      ST_SETTLE = 3'h2,
      ST_WAIT   = 3'h3,
      ST_PULSE  = 3'h4,
      ST_POST   = 3'h5,
      ST_TAKE   = 3'h6
   } mdcx_state_t;

   // One stored program line.
   typedef struct packed {
      mdcx_cmd_t   cmd;
      logic        axis_sel;
      logic [31:0] data_x;
      logic [31:0] data_y;
      logic        cont_minus;
      logic [1:0]  speed_sel;
      logic [1:0]  timer_sel;
      logic        finish_pulse_select;
   } mdcx_line_t;

   // Command to one axis pulse generator; strobes are one cycle long.
   typedef struct packed {
      logic        start;
      logic        continuous;
      logic        dir_minus;
      logic [31:0] pulses;
      logic [1:0]  accel_mode;
      logic [23:0] speed;
      logic        dec_stop;
      logic        imm_stop;
      logic        origin_search;
      logic [2:0]  origin_mode;
   } mdcx_axis_cmd_t;

   // Acceleration mode code that means constant speed.
   localparam logic [1:0] ACC_CONSTANT = 2'h0;

   // Register byte offsets.
   localparam logic [7:0] REG_MODE         = 8'h00;
   localparam logic [7:0] REG_FINISH_WIDTH = 8'h04;
   localparam logic [7:0] REG_POST_TIMER1  = 8'h08;
   localparam logic [7:0] REG_POST_TIMER2  = 8'h0c;
   localparam logic [7:0] REG_POST_TIMER3  = 8'h10;
   localparam logic [7:0] REG_SCALE        = 8'h14;
   localparam logic [7:0] REG_SPEED1       = 8'h18;
   localparam logic [7:0] REG_SPEED2       = 8'h1c;
   localparam logic [7:0] REG_SPEED3       = 8'h20;
   localparam logic [7:0] REG_SPEED4       = 8'h24;
   localparam logic [7:0] REG_STATUS       = 8'h28;

   // Field positions.
   localparam int MODE_FINISH_EN_BIT = 0;
   localparam int MODE_ORIGIN_LSB    = 1;
   localparam int SCALE_DEN_LSB      = 16;
   localparam int SPEED_VALUE_LSB    = 8;

   // Values after reset.
   localparam logic [31:0] RST_MODE         = 32'h0000_0000;
   localparam logic [31:0] RST_FINISH_WIDTH = 32'h0000_000a;
   localparam logic [31:0] RST_POST_TIMER   = 32'h0000_0000;
   localparam logic [31:0] RST_SCALE        = 32'h0001_0001;
   localparam logic [31:0] RST_SPEED        = 32'h0000_0100;

endpackage : mdcx_pkg

// ---- mdcx_down_timer.sv ----
// Loadable down counter used for the finish pulse width and post timers.
// Assumes a synchronous load strobe and a reset already synchronised.
`timescale 1ns/10ps
module mdcx_down_timer (
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // Control.
   input  wire logic        load_in,
   input  wire logic [31:0] count_in,
   // Status.
   output logic             busy_out
);
   logic [31:0] cnt_q;

   // A load of N keeps busy high for exactly N cycles after the load edge.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= 32'h0000_0000;
      end else if (load_in) begin
         cnt_q <= count_in;
      end else if (cnt_q != 32'h0000_0000) begin
         cnt_q <= cnt_q - 32'h0000_0001;
      end
   end

   // A zero count is never busy, so a zero timer costs no wait.
   assign busy_out = (cnt_q != 32'h0000_0000);
endmodule : mdcx_down_timer

// ---- mdcx_executor.sv ----
// Program line executor for a two-axis stepper motion controller.
// Assumes each axis raises its busy input no later than the cycle after a
// start strobe and holds it until motion or an origin search has ended.
// Summary of operation
// - Single-axis relative move drives by signed offset; next line waits for completion.
// - Positive offset drives plus (clockwise), negative drives minus (counterclockwise).
// - Scale numerator equal denominator, or denominator zero, means raw pulses; otherwise data is scaled.
// - Speed field picks one of four profiles of acceleration mode and speed.
// - Timer zero means no wait; one to three insert that post timer, except after origin search or non-blocking lines.
// - With finish pulse selected, post timer starts only once pulse is asserted.
// - Finish pulse goes out after the move only when the line selects it.
// - Pulse needs mode enable; its width comes from a configurable register.
// - Dual-axis relative move starts X and Y together; advance after both finish.
// - Relative move start begins the move and advances at once.
// - Continuous move drives endlessly in given direction and advances at once.
// - Decelerating stop ramps down, or stops at once when constant speed.
// - Immediate stop halts pulses at once, then applies the post timer.
// - A stop on a stationary axis only waits its timer, then advances.
// - Origin search runs the configured search mode; advance after it finishes.
// - Finish pulse selection decides a pulse after origin search ends.
`timescale 1ns/10ps
module mdcx_executor (
   // Clock and reset.
   input  wire logic                               clk_in,
   input  wire logic                               rst_b_in,
   // Register port.
   input  wire logic [7:0]                         reg_addr_in,
   input  wire logic [31:0]                        reg_wdata_in,
   input  wire logic                               reg_wr_in,
   input  wire logic                               reg_rd_in,
   output logic [31:0]                             reg_rdata_out,
   // Stored program line source.
   input  wire logic                               line_valid_in,
   input  wire mdcx_pkg::mdcx_line_t               line_in,
   output logic                                    line_take_out,
   // Axis pulse generators, index 0 is X and 1 is Y.
   input  wire logic [1:0]                         axis_busy_in,
   output mdcx_pkg::mdcx_axis_cmd_t [1:0]          axis_cmd_out,
   // Parallel control connector.
   output logic                                    drive_or_finish_pulse_out
);
   logic                      rst_s1_q;
   logic                      rst_s2_q;
   logic                      rst_b;
   logic [31:0]               mode_q;
   logic [31:0]               width_q;
   logic [31:0]               post_q [3];
   logic [31:0]               scale_q;
   logic [31:0]               spd_q [4];
   logic [31:0]               rdata_q;
   mdcx_pkg::mdcx_state_t     st_q;
   mdcx_pkg::mdcx_line_t      line_q;
   mdcx_pkg::mdcx_axis_cmd_t [1:0] cmd_q;
   logic [1:0]                sel_mask_q;
   logic [1:0]                cur_acc_q [2];
   logic                      out_q;
   logic                      mode_en;
   logic                      pulse_go;
   logic                      pulse_load;
   logic                      post_load;
   logic                      pulse_busy;
   logic                      post_busy;
   logic [31:0]               post_count;

   // Magnitude of a signed position value.
   function automatic logic [31:0] mag(input logic [31:0] v);
      return v[31] ? (32'h0000_0000 - v) : v;
   endfunction : mag

   // Pulse count from a position value under the current scale setting.
   function automatic logic [31:0] scale_mag(input logic [31:0] v, input logic [31:0] sc);
      logic [47:0] prod;
      prod = 48'h0;
      if (sc[15:0] == sc[31:16] || sc[31:16] == 16'h0000) begin
         return mag(v);
      end
      prod = mag(v) * sc[15:0];
      return 32'(prod / {32'h0000_0000, sc[31:16]});
   endfunction : scale_mag

   // Lines whose completion holds the program pointer.
   function automatic logic is_blocking(input mdcx_pkg::mdcx_cmd_t c);
      return c inside {mdcx_pkg::CMD_RELATIVE_MOVE, mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE,
                       mdcx_pkg::CMD_DECELERATING_STOP, mdcx_pkg::CMD_IMMEDIATE_STOP,
                       mdcx_pkg::CMD_ORIGIN_SEARCH};
   endfunction : is_blocking

   // Lines that may end with a finish pulse.
   function automatic logic has_pulse(input mdcx_pkg::mdcx_cmd_t c);
      return c inside {mdcx_pkg::CMD_RELATIVE_MOVE, mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE,
                       mdcx_pkg::CMD_ORIGIN_SEARCH};
   endfunction : has_pulse

   // Reset is released through two flops so every flop behind them leaves reset together.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   assign rst_b = rst_s2_q;

   // Configuration registers; the status word is read only.
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         mode_q  <= mdcx_pkg::RST_MODE;
         width_q <= mdcx_pkg::RST_FINISH_WIDTH;
         scale_q <= mdcx_pkg::RST_SCALE;
         for (int i = 0; i < 3; i++) begin
            post_q[i] <= mdcx_pkg::RST_POST_TIMER;
         end
         for (int i = 0; i < 4; i++) begin
            spd_q[i] <= mdcx_pkg::RST_SPEED;
         end
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            mdcx_pkg::REG_MODE:         mode_q    <= reg_wdata_in;
            mdcx_pkg::REG_FINISH_WIDTH: width_q   <= reg_wdata_in;
            mdcx_pkg::REG_POST_TIMER1:  post_q[0] <= reg_wdata_in;
            mdcx_pkg::REG_POST_TIMER2:  post_q[1] <= reg_wdata_in;
            mdcx_pkg::REG_POST_TIMER3:  post_q[2] <= reg_wdata_in;
            mdcx_pkg::REG_SCALE:        scale_q   <= reg_wdata_in;
            mdcx_pkg::REG_SPEED1:       spd_q[0]  <= reg_wdata_in;
            mdcx_pkg::REG_SPEED2:       spd_q[1]  <= reg_wdata_in;
            mdcx_pkg::REG_SPEED3:       spd_q[2]  <= reg_wdata_in;
            mdcx_pkg::REG_SPEED4:       spd_q[3]  <= reg_wdata_in;
            default: begin
            end
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            mdcx_pkg::REG_MODE:         rdata_q <= mode_q;
            mdcx_pkg::REG_FINISH_WIDTH: rdata_q <= width_q;
            mdcx_pkg::REG_POST_TIMER1:  rdata_q <= post_q[0];
            mdcx_pkg::REG_POST_TIMER2:  rdata_q <= post_q[1];
            mdcx_pkg::REG_POST_TIMER3:  rdata_q <= post_q[2];
            mdcx_pkg::REG_SCALE:        rdata_q <= scale_q;
            mdcx_pkg::REG_SPEED1:       rdata_q <= spd_q[0];
            mdcx_pkg::REG_SPEED2:       rdata_q <= spd_q[1];
            mdcx_pkg::REG_SPEED3:       rdata_q <= spd_q[2];
            mdcx_pkg::REG_SPEED4:       rdata_q <= spd_q[3];
            mdcx_pkg::REG_STATUS:       rdata_q <= {25'h0, out_q, axis_busy_in, 1'b0, st_q};
            default:                    rdata_q <= 32'h0000_0000;
         endcase
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end
   assign reg_rdata_out = rdata_q;

   // Pulse and timer launches; the pulse is never raised without the mode enable.
   assign mode_en    = mode_q[mdcx_pkg::MODE_FINISH_EN_BIT];
   assign pulse_go   = line_q.finish_pulse_select && mode_en && has_pulse(line_q.cmd);
   assign pulse_load = (st_q == mdcx_pkg::ST_WAIT) && ((axis_busy_in & sel_mask_q) == 2'b00)
                       && pulse_go;
   assign post_load  = (st_q == mdcx_pkg::ST_PULSE)
                       || ((st_q == mdcx_pkg::ST_WAIT) && ((axis_busy_in & sel_mask_q) == 2'b00)
                           && !pulse_go);
   // Origin search carries no timer field, so it never waits after its pulse.
   assign post_count = (line_q.timer_sel == 2'h0 || line_q.cmd == mdcx_pkg::CMD_ORIGIN_SEARCH)
                       ? 32'h0000_0000 : post_q[line_q.timer_sel - 2'h1];

   // Finish pulse width counter.
   mdcx_down_timer u_pulse_tmr (
      .clk_in   (clk_in),
      .rst_b_in (rst_b),
      .load_in  (pulse_load),
      .count_in (width_q),
      .busy_out (pulse_busy)
   );

   // Post timer counter.
   mdcx_down_timer u_post_tmr (
      .clk_in   (clk_in),
      .rst_b_in (rst_b),
      .load_in  (post_load),
      .count_in (post_count),
      .busy_out (post_busy)
   );

   // Sequencer: one line at a time; blocking lines held until completion and post timer.
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         st_q       <= mdcx_pkg::ST_IDLE;
         line_q     <= '0;
         sel_mask_q <= 2'b00;
      end else begin
         case (st_q)
            mdcx_pkg::ST_IDLE: begin
               if (line_valid_in) begin
                  line_q <= line_in;
                  st_q   <= mdcx_pkg::ST_ISSUE;
               end
            end
            mdcx_pkg::ST_ISSUE: begin
               if (line_q.cmd == mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE) begin
                  sel_mask_q <= 2'b11;
               end else begin
                  sel_mask_q <= line_q.axis_sel ? 2'b10 : 2'b01;
               end
               st_q <= mdcx_pkg::ST_SETTLE;
            end
            mdcx_pkg::ST_SETTLE: begin
               // Non-blocking starts advance as soon as motion is launched.
               st_q <= is_blocking(line_q.cmd) ? mdcx_pkg::ST_WAIT : mdcx_pkg::ST_TAKE;
            end
            mdcx_pkg::ST_WAIT: begin
               // A stationary axis is never busy, so a stop falls straight through.
               if ((axis_busy_in & sel_mask_q) == 2'b00) begin
                  st_q <= pulse_go ? mdcx_pkg::ST_PULSE : mdcx_pkg::ST_POST;
               end
            end
            mdcx_pkg::ST_PULSE: begin
               st_q <= mdcx_pkg::ST_POST;
            end
            mdcx_pkg::ST_POST: begin
               if (!post_busy) begin
                  st_q <= mdcx_pkg::ST_TAKE;
               end
            end
            mdcx_pkg::ST_TAKE: begin
               st_q <= mdcx_pkg::ST_IDLE;
            end
            default: begin
               st_q <= mdcx_pkg::ST_IDLE;
            end
         endcase
      end
   end
   assign line_take_out = (st_q == mdcx_pkg::ST_TAKE);

   // Axis command strobes, built in the issue cycle and cleared one cycle later.
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         cmd_q        <= '0;
         cur_acc_q[0] <= mdcx_pkg::ACC_CONSTANT;
         cur_acc_q[1] <= mdcx_pkg::ACC_CONSTANT;
      end else begin
         for (int a = 0; a < 2; a++) begin
            cmd_q[a].start         <= 1'b0;
            cmd_q[a].dec_stop      <= 1'b0;
            cmd_q[a].imm_stop      <= 1'b0;
            cmd_q[a].origin_search <= 1'b0;
            if (st_q == mdcx_pkg::ST_ISSUE &&
                (line_q.cmd == mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE ||
                 line_q.axis_sel == a[0])) begin
               case (line_q.cmd)
                  mdcx_pkg::CMD_RELATIVE_MOVE, mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE,
                  mdcx_pkg::CMD_RELATIVE_MOVE_START, mdcx_pkg::CMD_CONTINUOUS_MOVE_START: begin
                     cmd_q[a].start      <= 1'b1;
                     cmd_q[a].continuous <= (line_q.cmd == mdcx_pkg::CMD_CONTINUOUS_MOVE_START);
                     if (line_q.cmd == mdcx_pkg::CMD_CONTINUOUS_MOVE_START) begin
                        cmd_q[a].dir_minus <= line_q.cont_minus;
                        cmd_q[a].pulses    <= 32'h0000_0000;
                     end else begin
                        cmd_q[a].dir_minus <= (a == 0) ? line_q.data_x[31]
                                                       : line_q.data_y[31];
                        cmd_q[a].pulses    <= scale_mag((a == 0) ? line_q.data_x : line_q.data_y,
                                                        scale_q);
                     end
                     cmd_q[a].accel_mode <= spd_q[line_q.speed_sel][1:0];
                     cmd_q[a].speed      <= spd_q[line_q.speed_sel][31:mdcx_pkg::SPEED_VALUE_LSB];
                     cur_acc_q[a]        <= spd_q[line_q.speed_sel][1:0];
                  end
                  mdcx_pkg::CMD_DECELERATING_STOP: begin
                     // Constant speed has no ramp to follow, so it stops at once.
                     if (cur_acc_q[a] == mdcx_pkg::ACC_CONSTANT) begin
                        cmd_q[a].imm_stop <= 1'b1;
                     end else begin
                        cmd_q[a].dec_stop <= 1'b1;
                     end
                  end
                  mdcx_pkg::CMD_IMMEDIATE_STOP: begin
                     cmd_q[a].imm_stop <= 1'b1;
                  end
                  mdcx_pkg::CMD_ORIGIN_SEARCH: begin
                     cmd_q[a].origin_search <= 1'b1;
                     cmd_q[a].origin_mode   <= mode_q[mdcx_pkg::MODE_ORIGIN_LSB +: 3];
                  end
                  default: begin
                  end
               endcase
            end
         end
      end
   end
   assign axis_cmd_out = cmd_q;

   // The shared pin shows X drive activity unless finish pulses are enabled.
   always_ff @(posedge clk_in or negedge rst_b) begin
      if (!rst_b) begin
         out_q <= 1'b0;
      end else begin
         out_q <= mode_en ? pulse_busy : axis_busy_in[0];
      end
   end
   assign drive_or_finish_pulse_out = out_q;

   // Checks on the sequencer and its outputs.
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b);

   chk_block_hold: assert property ((st_q == mdcx_pkg::ST_WAIT) &&
      ((axis_busy_in & sel_mask_q) != 2'b00) |=> (st_q == mdcx_pkg::ST_WAIT) && !line_take_out)
      else $error("blocking line left wait while axis busy");
   chk_dir_sign: assert property (cmd_q[0].start && !cmd_q[0].continuous |->
      cmd_q[0].dir_minus == ((line_q.cmd == mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE ||
                              !line_q.axis_sel) ? line_q.data_x[31] : 1'b0))
      else $error("direction does not follow offset sign");
   chk_scale_ident: assert property (cmd_q[0].start && !cmd_q[0].continuous &&
      (scale_q[15:0] == scale_q[31:16]) |-> cmd_q[0].pulses == mag(line_q.data_x))
      else $error("unit scale did not pass raw pulses");
   chk_profile_use: assert property (cmd_q[0].start |->
      cmd_q[0].accel_mode == spd_q[line_q.speed_sel][1:0])
      else $error("speed profile not applied");
   chk_zero_timer: assert property ((st_q == mdcx_pkg::ST_POST) &&
      ($past(st_q) != mdcx_pkg::ST_POST) && !post_busy |=> line_take_out)
      else $error("zero timer caused a wait");
   chk_pulse_first: assert property ((st_q == mdcx_pkg::ST_PULSE) && pulse_busy |=>
      drive_or_finish_pulse_out && (st_q == mdcx_pkg::ST_POST))
      else $error("post timer began before finish pulse");
   chk_pulse_gate: assert property (mode_en && $rose(drive_or_finish_pulse_out) |->
      $past(st_q, 2) == mdcx_pkg::ST_WAIT && $past(pulse_go, 2))
      else $error("finish pulse without selection");
   chk_nonblock_go: assert property ((st_q == mdcx_pkg::ST_SETTLE) &&
      !is_blocking(line_q.cmd) |=> line_take_out)
      else $error("non-blocking start did not advance");
   chk_const_stop: assert property (cmd_q[0].dec_stop |->
      cur_acc_q[0] != mdcx_pkg::ACC_CONSTANT && !cmd_q[0].imm_stop)
      else $error("constant speed axis got a ramped stop");
   chk_one_take: assert property (line_take_out |=> !line_take_out ##1
      (st_q == mdcx_pkg::ST_IDLE || st_q == mdcx_pkg::ST_ISSUE))
      else $error("line pointer advanced twice");

   cov_dual_move: cover property (cmd_q[0].start && cmd_q[1].start ##[1:200] line_take_out);
   cov_pulse_out: cover property ((st_q == mdcx_pkg::ST_PULSE) ##[1:50] line_take_out);
   cov_dec_stop: cover property (cmd_q[0].dec_stop ##[1:200] line_take_out);
   cov_cont_go: cover property (cmd_q[0].start && cmd_q[0].continuous);
endmodule : mdcx_executor

// ---- mdcx_axis_model.sv ----
// Behavioural axis pulse generator standing behind one axis command port.
// Assumes start and stop strobes from the executor last one cycle.
`timescale 1ns/10ps
module mdcx_axis_model (
   // Clock and reset.
   input  wire logic                     clk_in,
   input  wire logic                     rst_b_in,
   // Command in, motion status out.
   input  wire mdcx_pkg::mdcx_axis_cmd_t cmd_in,
   output logic                          busy_out
);
   logic [31:0] left_q;
   logic        free_q;
   // One busy cycle per pulse keeps runs short; a ramped stop takes three cycles.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_out <= 1'b0;
         left_q <= 32'h0;
         free_q <= 1'b0;
      end else if (cmd_in.imm_stop) begin
         busy_out <= 1'b0;
         left_q <= 32'h0;
         free_q <= 1'b0;
      end else if (cmd_in.dec_stop) begin
         free_q <= 1'b0;
         left_q <= busy_out ? 32'h3 : 32'h0;
      end else if (cmd_in.start | cmd_in.origin_search) begin
         busy_out <= 1'b1;
         free_q <= cmd_in.start & cmd_in.continuous;
         left_q <= cmd_in.origin_search ? 32'h6 : cmd_in.pulses;
      end else if (!free_q && left_q != 32'h0) begin
         left_q <= left_q - 32'h1;
         busy_out <= (left_q > 32'h1);
      end
   end
endmodule : mdcx_axis_model

// ---- mdcx_executor_tb.sv ----
// Self-checking bench for the executor: register tasks and program line runs.
// Assumes two axis models answer the start strobes on the next cycle.
`timescale 1ns/10ps
module mdcx_executor_tb;
   logic                           clk_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0;
   logic                           lv = 1'b0, take, pin, bt;
   logic [7:0]                     addr = 8'h00;
   logic [31:0]                    wdata = 32'h0, rdata;
   logic [1:0]                     busy;
   logic [2:0]                     om;
   mdcx_pkg::mdcx_line_t           ln = '0;
   mdcx_pkg::mdcx_axis_cmd_t [1:0] ac;
   mdcx_pkg::mdcx_axis_cmd_t       cap [2];
   int                             error_cnt = 0, num_checks = 0, lat, lat0;
   int                             imm_cnt = 0, dec_cnt = 0, pin_cnt = 0, dual_cnt = 0;
   // A 10 MHz clock.
   always #50 clk_in = ~clk_in;
   mdcx_executor i_mdcx_executor (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .line_valid_in(lv), .line_in(ln), .line_take_out(take), .axis_busy_in(busy),
      .axis_cmd_out(ac), .drive_or_finish_pulse_out(pin));
   mdcx_axis_model i_axis_x (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_in(ac[0]),
      .busy_out(busy[0]));
   mdcx_axis_model i_axis_y (.clk_in(clk_in), .rst_b_in(rst_b_in), .cmd_in(ac[1]),
      .busy_out(busy[1]));
   // Strobes are counted at each edge, before that edge's updates land.
   always @(posedge clk_in) begin
      for (int i = 0; i < 2; i++) begin
         if (ac[i].start) cap[i] = ac[i];
         if (ac[i].imm_stop) imm_cnt++;
         if (ac[i].dec_stop) dec_cnt++;
         if (ac[i].origin_search) om = ac[i].origin_mode;
      end
      if (ac[0].start && ac[1].start) dual_cnt++;
      if (pin) pin_cnt++;
   end
   task automatic test_done;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   // Wide enough that joined fields compared in one call are never cut short.
   task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wreg
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rchk
   // Presents one line and counts edges until it is taken; bt is axis motion then.
   task automatic run(input mdcx_pkg::mdcx_line_t l);
      @(posedge clk_in);
      ln <= l;
      lv <= 1'b1;
      lat = 0;
      do begin
         @(posedge clk_in);
         lat++;
         bt = |busy;
      end while (take !== 1'b1 && lat < 300);
      lv <= 1'b0;
      #1 if (lat >= 300) error_cnt++;
   endtask : run
   function automatic mdcx_pkg::mdcx_line_t mk(input mdcx_pkg::mdcx_cmd_t c, input logic ax,
         input logic [31:0] dx, input logic [31:0] dy, input logic [1:0] sp,
         input logic [1:0] tm, input logic fp);
      mk = '{c, ax, dx, dy, dx[31], sp, tm, fp};
   endfunction : mk
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rchk(mdcx_pkg::REG_FINISH_WIDTH, 32'ha);
      rchk(mdcx_pkg::REG_SCALE, 32'h0001_0001);
      rchk(mdcx_pkg::REG_SPEED4, 32'h100);
      rchk(8'h3c, 32'h0);
      wreg(mdcx_pkg::REG_SPEED2, 32'h2001);
      wreg(mdcx_pkg::REG_POST_TIMER2, 32'h14);
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h1, 2'h0, 1'b0));
      lat0 = lat;
      chk(cap[0].pulses, 32'h5);
      chk(cap[0].dir_minus, 32'h0);
      chk({cap[0].accel_mode, cap[0].speed}, 32'h100_0020);
      chk(bt, 32'h0);
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h1, 2'h2, 1'b0));
      chk(lat - lat0, 32'h14);
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b1, 32'h0, 32'hffff_fff9, 2'h0, 2'h0, 1'b0));
      chk({cap[1].dir_minus, cap[1].pulses}, {1'b1, 32'h7});
      chk(cap[1].speed, 32'h1);
      wreg(mdcx_pkg::REG_SCALE, 32'h0001_0002);
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h0, 2'h0, 1'b0));
      chk(cap[0].pulses, 32'ha);
      wreg(mdcx_pkg::REG_SCALE, 32'h0001_0001);
      run(mk(mdcx_pkg::CMD_DUAL_AXIS_RELATIVE_MOVE, 1'b0, 32'h3, 32'hffff_fffc, 2'h0, 2'h0,
         1'b0));
      chk(dual_cnt, 32'h1);
      chk({cap[1].pulses, cap[0].pulses, bt}, {32'h4, 32'h3, 1'b0});
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE_START, 1'b0, 32'h32, 32'h0, 2'h0, 2'h0, 1'b0));
      chk({lat, bt}, {32'h4, 1'b1});
      run(mk(mdcx_pkg::CMD_IMMEDIATE_STOP, 1'b0, 32'h0, 32'h0, 2'h0, 2'h0, 1'b0));
      chk({imm_cnt, bt}, {32'h1, 1'b0});
      run(mk(mdcx_pkg::CMD_CONTINUOUS_MOVE_START, 1'b0, 32'hffff_ffff, 32'h0, 2'h1, 2'h0, 1'b0));
      chk({lat, cap[0].continuous, cap[0].dir_minus}, {32'h4, 2'h3});
      run(mk(mdcx_pkg::CMD_DECELERATING_STOP, 1'b0, 32'h0, 32'h0, 2'h0, 2'h0, 1'b0));
      chk({dec_cnt, imm_cnt, bt}, {32'h1, 32'h1, 1'b0});
      run(mk(mdcx_pkg::CMD_CONTINUOUS_MOVE_START, 1'b0, 32'h1, 32'h0, 2'h0, 2'h0, 1'b0));
      run(mk(mdcx_pkg::CMD_DECELERATING_STOP, 1'b0, 32'h0, 32'h0, 2'h0, 2'h0, 1'b0));
      chk({dec_cnt, imm_cnt, bt}, {32'h1, 32'h2, 1'b0});
      run(mk(mdcx_pkg::CMD_DECELERATING_STOP, 1'b0, 32'h0, 32'h0, 2'h0, 2'h0, 1'b0));
      lat0 = lat;
      run(mk(mdcx_pkg::CMD_DECELERATING_STOP, 1'b0, 32'h0, 32'h0, 2'h0, 2'h2, 1'b0));
      chk(lat - lat0, 32'h14);
      wreg(mdcx_pkg::REG_MODE, 32'h7);
      wreg(mdcx_pkg::REG_FINISH_WIDTH, 32'h4);
      pin_cnt = 0;
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h0, 2'h2, 1'b1));
      chk(pin_cnt, 32'h4);
      pin_cnt = 0;
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h0, 2'h2, 1'b0));
      chk(pin_cnt, 32'h0);
      run(mk(mdcx_pkg::CMD_ORIGIN_SEARCH, 1'b0, 32'h0, 32'h0, 2'h0, 2'h0, 1'b1));
      chk({om, bt}, {3'h3, 1'b0});
      repeat (6) @(posedge clk_in);
      #1 chk(pin_cnt, 32'h4);
      wreg(mdcx_pkg::REG_MODE, 32'h0);
      pin_cnt = 0;
      run(mk(mdcx_pkg::CMD_RELATIVE_MOVE, 1'b0, 32'h5, 32'h0, 2'h0, 2'h2, 1'b1));
      chk(pin_cnt, 32'h5);
      test_done;
   end
   // Watchdog well beyond the few hundred cycles the sequence needs.
   initial begin
      #3000000;
      error_cnt++;
      test_done;
   end
endmodule : mdcx_executor_tb
